// ---- design/can_wake_frame_pattern_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wake_frame_defs.svh"

module can_wake_frame_pattern_regs (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic soft_rst_i,
    input wire logic restart_i,
    input wire wake_frame_pkg::reg_req_s reg_req_i,
    input wire wake_frame_pkg::wake_ref_s wake_ref_i,
    input wire logic rx_valid_i,
    input wire wake_frame_pkg::rx_frame_s rx_frame_i,
    output logic [15:0] rdata_o,
    output logic rdata_valid_o,
    output logic wake_up_frame_o,
    output logic check_done_o
);
    logic rst_meta_n;
    logic rst_n;
    logic [15:0] mask_high_reg;
    logic [12:0] mask_low_reg;
    logic [3:0] len_code_reg;
    logic [15:0] bytes_7_6_reg;
    logic [15:0] bytes_5_4_reg;
    logic [15:0] rdata_next;
    logic [28:0] id_mask;
    logic [28:0] id_width;
    logic [28:0] id_diff;
    logic [3:0] byte_count;
    logic [63:0] exp_payload;
    logic [7:0] byte_ok;
    logic id_ok;
    logic len_ok;
    logic match_next;

    // Release reset through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    wire wr_mask_high = reg_req_i.wr_en && (reg_req_i.addr == `ADDR_MASK_HIGH);
    wire wr_mask_low = reg_req_i.wr_en && (reg_req_i.addr == `ADDR_MASK_LOW);
    wire wr_len = reg_req_i.wr_en && (reg_req_i.addr == `ADDR_LEN_CODE);
    wire wr_b76 = reg_req_i.wr_en && (reg_req_i.addr == `ADDR_BYTES_7_6);
    wire wr_b54 = reg_req_i.wr_en && (reg_req_i.addr == `ADDR_BYTES_5_4);

    // Restart blocks all register writes; reserved bits are never stored
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mask_high_reg <= `REG16_RESET;
            mask_low_reg <= `REG13_RESET;
            len_code_reg <= `LEN_RESET;
            bytes_7_6_reg <= `REG16_RESET;
            bytes_5_4_reg <= `REG16_RESET;
        end else if (soft_rst_i) begin
            mask_high_reg <= `REG16_RESET;
            mask_low_reg <= `REG13_RESET;
            len_code_reg <= `LEN_RESET;
            bytes_7_6_reg <= `REG16_RESET;
            bytes_5_4_reg <= `REG16_RESET;
        end else if (!restart_i) begin
            if (wr_mask_high) begin
                mask_high_reg <= reg_req_i.wdata;
            end
            if (wr_mask_low) begin
                mask_low_reg <= {reg_req_i.wdata[`MASK_LOW_UPPER_MSB:`MASK_LOW_UPPER_LSB],
                    reg_req_i.wdata[`MASK_LOW_LOWER_MSB:`MASK_LOW_LOWER_LSB]};
            end
            if (wr_len) begin
                len_code_reg <= reg_req_i.wdata[`LEN_CODE_MSB:0];
            end
            if (wr_b76) begin
                bytes_7_6_reg <= reg_req_i.wdata;
            end
            if (wr_b54) begin
                bytes_5_4_reg <= reg_req_i.wdata;
            end
        end
    end

    // Read path; unmapped addresses read zero
    always_comb begin
        rdata_next = `REG16_RESET;
        if (reg_req_i.addr == `ADDR_MASK_HIGH) begin
            rdata_next = mask_high_reg;
        end else if (reg_req_i.addr == `ADDR_MASK_LOW) begin
            rdata_next = {mask_low_reg[12:5], 1'b0, mask_low_reg[4:0], 2'b00};
        end else if (reg_req_i.addr == `ADDR_LEN_CODE) begin
            rdata_next = {12'h000, len_code_reg};
        end else if (reg_req_i.addr == `ADDR_BYTES_7_6) begin
            rdata_next = bytes_7_6_reg;
        end else if (reg_req_i.addr == `ADDR_BYTES_5_4) begin
            rdata_next = bytes_5_4_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= `REG16_RESET;
            rdata_valid_o <= 1'b0;
        end else begin
            rdata_o <= reg_req_i.rd_en ? rdata_next : `REG16_RESET;
            rdata_valid_o <= reg_req_i.rd_en;
        end
    end

    // Identifier compare: only masked-in bits within the selected width
    assign id_width = rx_frame_i.ext_id ? {29{1'b1}} : 29'h0000_07FF;
    assign id_mask = {mask_high_reg, mask_low_reg} & id_width;
    assign id_diff = (rx_frame_i.id ^ wake_ref_i.id) & id_mask;
    assign id_ok = (id_diff == 29'h0000_0000) && (rx_frame_i.ext_id == wake_ref_i.ext_id);

    // Bit-for-bit code match; 8..15 are not interchangeable
    assign len_ok = (rx_frame_i.len_code == len_code_reg);
    assign byte_count = (len_code_reg >= `LEN_CODE_FULL) ? `LEN_CODE_FULL : len_code_reg;
    assign exp_payload = {bytes_7_6_reg, bytes_5_4_reg, wake_ref_i.bytes_3_0};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_byte
            // Bytes beyond the length are not compared
            assign byte_ok[gi] = (4'(gi) >= byte_count) ||
                (rx_frame_i.payload[gi*8 +: 8] == exp_payload[gi*8 +: 8]);
        end
    endgenerate

    assign match_next = id_ok && len_ok && (&byte_ok);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wake_up_frame_o <= 1'b0;
            check_done_o <= 1'b0;
        end else begin
            wake_up_frame_o <= rx_valid_i && match_next;
            check_done_o <= rx_valid_i;
        end
    end

    a_mask_low_pack: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        wr_mask_low && !soft_rst_i && !restart_i ##1 reg_req_i.rd_en &&
        reg_req_i.addr == `ADDR_MASK_LOW |=> rdata_o == ($past(reg_req_i.wdata, 2) & 16'hFF7C))
        else $error("Low mask readback wrong");
    a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        $past(reg_req_i.rd_en) && $past(reg_req_i.addr) == `ADDR_LEN_CODE |->
        rdata_o[15:4] == 12'h000)
        else $error("Reserved length bits not zero");
    a_soft_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        soft_rst_i |=> mask_low_reg == `REG13_RESET && len_code_reg == `LEN_RESET &&
        bytes_7_6_reg == `REG16_RESET && bytes_5_4_reg == `REG16_RESET &&
        mask_high_reg == `REG16_RESET)
        else $error("Soft reset did not clear");
    a_restart_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        restart_i && !soft_rst_i |=> $stable(bytes_7_6_reg) && $stable(bytes_5_4_reg) &&
        $stable(mask_low_reg) && $stable(len_code_reg))
        else $error("Restart changed a register");
    a_len_exact: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && rx_frame_i.len_code != len_code_reg |=> !wake_up_frame_o)
        else $error("Match with differing length code");
    a_byte_mismatch: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && len_code_reg >= `LEN_CODE_FULL &&
        rx_frame_i.payload[63:56] != bytes_7_6_reg[15:8] |=> !wake_up_frame_o)
        else $error("Byte 7 ignored at full length");
    a_unmasked_free: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && mask_high_reg == 16'h0000 && mask_low_reg == 13'h0000 &&
        len_code_reg == `LEN_RESET && rx_frame_i.len_code == `LEN_RESET &&
        rx_frame_i.ext_id == wake_ref_i.ext_id |=> wake_up_frame_o)
        else $error("Unmasked frame not matched");
    a_std_width: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && !rx_frame_i.ext_id && id_diff[28:11] != 18'h0_0000 |-> 1'b0)
        else $error("Extended bits compared in standard mode");
    a_done_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        wake_up_frame_o |-> check_done_o && $past(rx_valid_i))
        else $error("Match without a frame");

    c_match: cover property (@(posedge sys_clk_i) disable iff (!rst_n) wake_up_frame_o);
    c_miss: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
        check_done_o && !wake_up_frame_o);
    c_restart: cover property (@(posedge sys_clk_i) disable iff (!rst_n) restart_i && wr_b76);
    c_long_code: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && len_code_reg > `LEN_CODE_FULL);

    a_high_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        wr_mask_high && !soft_rst_i && !restart_i
        |=> mask_high_reg == $past(reg_req_i.wdata))
        else $error("High mask write lost");

    a_len_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        wr_len && !soft_rst_i && !restart_i
        |=> len_code_reg == $past(reg_req_i.wdata[`LEN_CODE_MSB:0]))
        else $error("Length code write lost");

    a_b76_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        wr_b76 && !soft_rst_i && !restart_i
        |=> bytes_7_6_reg == $past(reg_req_i.wdata))
        else $error("Bytes 7 and 6 write lost");

    a_b54_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        wr_b54 && !soft_rst_i && !restart_i
        |=> bytes_5_4_reg == $past(reg_req_i.wdata))
        else $error("Bytes 5 and 4 write lost");

    a_low_reserved: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        $past(reg_req_i.rd_en) && $past(reg_req_i.addr) == `ADDR_MASK_LOW
        |-> rdata_o[7] == 1'b0 && rdata_o[1:0] == 2'b00)
        else $error("Low mask reserved bits not zero");

    a_len_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        $past(reg_req_i.rd_en) && $past(reg_req_i.addr) == `ADDR_LEN_CODE
        |-> rdata_o[`LEN_CODE_MSB:0] == $past(len_code_reg))
        else $error("Length code readback wrong");

    a_b76_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        $past(reg_req_i.rd_en) && $past(reg_req_i.addr) == `ADDR_BYTES_7_6
        |-> rdata_o == $past(bytes_7_6_reg))
        else $error("Bytes 7 and 6 readback wrong");

    a_b54_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        $past(reg_req_i.rd_en) && $past(reg_req_i.addr) == `ADDR_BYTES_5_4
        |-> rdata_o == $past(bytes_5_4_reg))
        else $error("Bytes 5 and 4 readback wrong");

    a_high_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        $past(reg_req_i.rd_en) && $past(reg_req_i.addr) == `ADDR_MASK_HIGH
        |-> rdata_o == $past(mask_high_reg))
        else $error("High mask readback wrong");

    a_restart_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        restart_i && !soft_rst_i
        |=> $stable(mask_low_reg))
        else $error("Restart changed low mask");

    a_restart_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        restart_i && !soft_rst_i
        |=> $stable(len_code_reg))
        else $error("Restart changed length code");

    a_restart_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        restart_i && !soft_rst_i
        |=> $stable(mask_high_reg))
        else $error("Restart changed high mask");

    a_mask_ignore: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && id_mask == 29'h0000_0000 && rx_frame_i.ext_id == wake_ref_i.ext_id &&
        len_ok && (&byte_ok) |=> wake_up_frame_o)
        else $error("Ignored id bits blocked a match");

    a_id_compare: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && id_diff != 29'h0000_0000
        |=> !wake_up_frame_o)
        else $error("Compared id bit differs but matched");

    a_std_ignore: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && !rx_frame_i.ext_id && !wake_ref_i.ext_id && len_ok && (&byte_ok) &&
        ((rx_frame_i.id ^ wake_ref_i.id) & {mask_high_reg, mask_low_reg} & 29'h0000_07FF) ==
        29'h0000_0000 |=> wake_up_frame_o) else $error("Standard id match missed");

    a_zero_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && len_code_reg == `LEN_RESET && len_ok && id_ok
        |=> wake_up_frame_o)
        else $error("Empty payload frame not matched");

    a_no_frame: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        !rx_valid_i
        |=> !wake_up_frame_o && !check_done_o)
        else $error("Check result without a frame");

    a_read_valid: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        reg_req_i.rd_en
        |=> rdata_valid_o)
        else $error("Read not answered");

    a_read_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        !reg_req_i.rd_en
        |=> !rdata_valid_o && rdata_o == `REG16_RESET)
        else $error("Read data without a read");

    c_std_match: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
        rx_valid_i && !rx_frame_i.ext_id && match_next);

endmodule : can_wake_frame_pattern_regs

`default_nettype wire

// ---- design/wake_frame_defs.svh ----
`ifndef WAKE_FRAME_DEFS_SVH
`define WAKE_FRAME_DEFS_SVH

// Register indices on the 7-bit register address
`define ADDR_MASK_HIGH 7'h34
`define ADDR_MASK_LOW 7'h35
`define ADDR_LEN_CODE 7'h36
`define ADDR_BYTES_7_6 7'h37
`define ADDR_BYTES_5_4 7'h38

// Field layout of the low mask register
`define MASK_LOW_UPPER_MSB 15
`define MASK_LOW_UPPER_LSB 8
`define MASK_LOW_LOWER_MSB 6
`define MASK_LOW_LOWER_LSB 2

// Length code field and its payload clamp
`define LEN_CODE_MSB 3
`define LEN_CODE_FULL 4'h8

// Standard identifier width in bits
`define STD_ID_BITS 11

// Reset values
`define REG16_RESET 16'h0000
`define REG13_RESET 13'h0000
`define LEN_RESET 4'h0
`endif

// ---- design/wake_frame_pkg.sv ----
package wake_frame_pkg;

    // One received frame as offered by the receiver
    typedef struct packed {
        logic [28:0] id;
        logic ext_id;
        logic [3:0] len_code;
        logic [63:0] payload;
    } rx_frame_s;

    // Register write or read request
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [6:0] addr;
        logic [15:0] wdata;
    } reg_req_s;

    // Expected-frame fields kept outside this bank
    typedef struct packed {
        logic [28:0] id;
        logic ext_id;
        logic [31:0] bytes_3_0;
    } wake_ref_s;

endpackage : wake_frame_pkg

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic soft_rst_i = 1'b0;
    logic restart_i = 1'b0;
    logic rx_valid_i = 1'b0;
    wake_frame_pkg::reg_req_s reg_req_i = '0;
    wake_frame_pkg::wake_ref_s wake_ref_i = '0;
    wake_frame_pkg::rx_frame_s rx_frame_i = '0;
    wake_frame_pkg::rx_frame_s f;
    logic [15:0] rdata_o;
    logic rdata_valid_o;
    logic wake_up_frame_o;
    logic check_done_o;
    logic [15:0] mh = 16'h0000, d76 = 16'h0000, d54 = 16'h0000;
    logic [12:0] ml = 13'h0000;
    logic [3:0] ln = 4'h0;
    logic [16:0] exp_q[$];
    logic [16:0] e;
    integer fail_count = 0, n_tests = 0, seed = 65139, cyc = 0, i, k;

    can_wake_frame_pattern_regs can_wake_frame_pattern_regs_inst (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .soft_rst_i(soft_rst_i),
        .restart_i(restart_i), .reg_req_i(reg_req_i), .wake_ref_i(wake_ref_i),
        .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i), .rdata_o(rdata_o),
        .rdata_valid_o(rdata_valid_o), .wake_up_frame_o(wake_up_frame_o),
        .check_done_o(check_done_o));

    initial forever #25 sys_clk_i = ~sys_clk_i;

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // Reference view of each register as the bus should show it
    function automatic logic [15:0] regval(input logic [6:0] a);
        case (a)
            7'h34: return mh;
            7'h35: return {ml[12:5], 1'b0, ml[4:0], 2'b00};
            7'h36: return {12'h000, ln};
            7'h37: return d76;
            7'h38: return d54;
            default: return 16'h0000;
        endcase
    endfunction : regval

    function automatic logic exp_match(input wake_frame_pkg::rx_frame_s x);
        logic [28:0] m;
        logic [63:0] p;
        logic ok;
        integer j, n;
        m = {mh, ml};
        p = {d76, d54, wake_ref_i.bytes_3_0};
        n = (ln > 4'h7) ? 8 : ln;
        ok = (x.ext_id === wake_ref_i.ext_id) && (x.len_code === ln);
        for (j = 0; j < 29; j++) begin
            if (m[j] && (j < 11 || wake_ref_i.ext_id) && x.id[j] !== wake_ref_i.id[j]) ok = 0;
        end
        for (j = 0; j < n * 8; j++) begin
            if (x.payload[j] !== p[j]) ok = 0;
        end
        return ok;
    endfunction : exp_match

    // Extra idle edge keeps a strobe from being set twice in one step
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_req_i = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        if (!restart_i && !soft_rst_i) begin
            case (a)
                7'h34: mh = d;
                7'h35: ml = {d[15:8], d[6:2]};
                7'h36: ln = d[3:0];
                7'h37: d76 = d;
                7'h38: d54 = d;
                default: ;
            endcase
        end
        @(negedge sys_clk_i);
        reg_req_i.wr_en = 1'b0;
        @(negedge sys_clk_i);
    endtask : wr

    // Write low mask and read it back on the very next edge
    task automatic wr_low_rd(input logic [15:0] d);
        reg_req_i = '{wr_en: 1'b1, rd_en: 1'b0, addr: 7'h35, wdata: d};
        ml = {d[15:8], d[6:2]};
        @(negedge sys_clk_i);
        reg_req_i = '{wr_en: 1'b0, rd_en: 1'b1, addr: 7'h35, wdata: 16'h0000};
        exp_q.push_back({1'b0, regval(7'h35)});
        @(negedge sys_clk_i);
        reg_req_i.rd_en = 1'b0;
        @(negedge sys_clk_i);
    endtask : wr_low_rd

    task automatic rdall;
        for (i = 8'h33; i <= 8'h39; i++) begin
            reg_req_i = '{wr_en: 1'b0, rd_en: 1'b1, addr: 7'(i), wdata: 16'h0000};
            exp_q.push_back({1'b0, regval(7'(i))});
            @(negedge sys_clk_i);
            reg_req_i.rd_en = 1'b0;
            @(negedge sys_clk_i);
        end
    endtask : rdall

    task automatic frm(input wake_frame_pkg::rx_frame_s x);
        rx_frame_i = x;
        rx_valid_i = 1'b1;
        exp_q.push_back({1'b1, 15'h0000, exp_match(x)});
        @(negedge sys_clk_i);
        rx_valid_i = 1'b0;
        @(negedge sys_clk_i);
    endtask : frm

    always @(negedge sys_clk_i) begin
        if (rdata_valid_o === 1'b1 || check_done_o === 1'b1) begin
            e = exp_q.pop_front();
            n_tests++;
            if (rdata_valid_o === 1'b1 && e !== {1'b0, rdata_o}) begin
                fail_count++;
                $display("MISMATCH at %0t: read %h want %h", $time, rdata_o, e);
            end else if (check_done_o === 1'b1 && e !== {1'b1, 15'h0000, wake_up_frame_o}) begin
                fail_count++;
                $display("MISMATCH at %0t: match %b want %b", $time, wake_up_frame_o, e[0]);
            end
        end
    end

    // Whole run is well under a thousand cycles
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            $display("MISMATCH at %0t: timeout", $time);
            final_report();
        end
    end

    initial begin
        repeat (10) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        rdall();
        $display("Test reset values done");
        for (k = 0; k < 5; k++) wr(7'(7'h34 + k), 16'hFFFF);
        rdall();
        wr_low_rd(16'($random(seed)));
        $display("Test full write done");
        for (k = 0; k < 5; k++) wr(7'(7'h34 + k), 16'($random(seed)));
        restart_i = 1'b1;
        for (k = 0; k < 5; k++) wr(7'(7'h34 + k), 16'h0000);
        restart_i = 1'b0;
        rdall();
        $display("Test restart done");
        soft_rst_i = 1'b1;
        wr(7'h36, 16'h0005);
        soft_rst_i = 1'b0;
        {mh, ml, ln, d76, d54} = '0;
        rdall();
        f = 98'({$random(seed), $random(seed), $random(seed), $random(seed)});
        f.len_code = 4'h0;
        f.ext_id = wake_ref_i.ext_id;
        frm(f);
        $display("Test soft reset done");
        for (k = 0; k < 16; k++) begin
            wr(7'h36, 16'(k));
            for (i = 0; i < 4; i++) wr(7'(8'h34 + i + (i > 1)), 16'($random(seed)));
            wake_ref_i = 62'({$random(seed), $random(seed)});
            f = '{id: wake_ref_i.id, ext_id: wake_ref_i.ext_id, len_code: ln,
                payload: {d76, d54, wake_ref_i.bytes_3_0}};
            frm(f);
            f.payload[63:56] = ~f.payload[63:56];
            frm(f);
            f.payload[63:56] = ~f.payload[63:56];
            f.id[$unsigned($random(seed)) % 29] ^= 1'b1;
            frm(f);
            f.id = wake_ref_i.id;
            f.len_code = ln ^ 4'h1;
            frm(f);
            f.len_code = ln;
            f.ext_id = ~f.ext_id;
            frm(f);
        end
        $display("Test frame compare done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
